//--- core/crf_map.vh
// register offsets, field positions, reset values and codes of the receive filter block
// Notes on behaviour
// (R1) range bits give 0-64, 65-128, 129-192 or 193-256 clocks per quantum
// (R2) each buffer compares its identifier plainly or through a mask
// (R3) a mask buffer, 0 or 2, never stores a message
// (R4) global setting: highest enabled mask serves buffers 4 to 15, both formats
// (R5) only the buffer's own extension bit picks standard or extended match
// (R6) one buffer stores a message; unmasked outranks masked
// (R7) among equal types the lowest number wins
// (R8) rewrite permit disables reception of the picked buffer 0 to 15
// (R9) while permit is set the picked buffer is no candidate
// (R10) a store under way into the picked buffer still completes
// (R11) initialization request clears the permit
// (R12) rewrite control resets to 00H, bits 6 to 4 read zero
// (R13) software sets pick code with permit clear, then permit, keeps code
// (R14) software checks fresh flag first, repairs config after a masked store
// (R15) a masked store also writes the received identifier
// (R16) four interrupt sources: fault, receive, transmit 0 and transmit 1
// (R17) transmit interrupt n rises when the controller clears request n
// (R18) only the controller clears a request; software sets cancel request; the code also clears requests on initialization request
// (R19) receive interrupt needs valid frame, filter pass, stored data, buffer enable
// (R20) receive interrupt by the seventh bit of the next frame
// (R21) fault interrupt on bus-off, error level change, overrun or wake-up
// (R22) no fault interrupts while wake flag is set; software clears it
// (R23) first mask: buffer 0 masks 1; second: buffer 2 masks 3
// (R24) with global set the highest defined mask covers all buffers above it; the code leaves buffer 3 unmasked then
// (R25) range bits act only while quantum range enable is 1
// (R26) fresh flag sets once a message is fully moved into the buffer
`ifndef CRF_MAP_VH
`define CRF_MAP_VH
`define CRF_ADDR_FRESH 16'hffb2
`define CRF_ADDR_REWRITE 16'hffb3
`define CRF_ADDR_MASKCFG 16'hffbb
`define CRF_REWRITE_RST 8'h00
`define CRF_MASKCFG_RST 8'h00
`define CRF_RW_PERMIT 7
`define CRF_RW_PICK_HI 3
`define CRF_RW_PICK_LO 0
`define CRF_MC_RANGE_HI 7
`define CRF_MC_RANGE_LO 6
`define CRF_MC_GLOBAL 2
`define CRF_MC_MASK2 1
`define CRF_MC_MASK1 0
`define CRF_MASKCFG_RW 8'hf7
`define CRF_SRC_NONE 2'h0
`define CRF_SRC_MASK0 2'h1
`define CRF_SRC_MASK1 2'h2
`define CRF_SRC_ISMASK 2'h3
`define CRF_ID_W 29
`define CRF_STD_BITS 29'h1ffc_0000
`define CRF_EXT_BITS 29'h1fff_ffff
`define CRF_TQ_STEP 9'h040
`endif

//--- core/crf_pick.v
// priority pick among matching receive buffers
`timescale 1ns/100ps
module crf_pick #(
   parameter NBUF = 16,
   parameter IW = 4
) (
   hit,
   masked,
   found,
   idx,
   via_mask
);
   input wire [NBUF-1:0] hit;
   input wire [NBUF-1:0] masked;
   output wire found;
   output wire [IW-1:0] idx;
   output wire via_mask;

   wire [NBUF-1:0] plain_hit;
   wire [NBUF-1:0] mask_hit;
   wire [IW-1:0] plain_idx;
   wire [IW-1:0] mask_idx;

   // lowest set bit of a vector
   function [IW-1:0] crf_lowest;
      input [NBUF-1:0] v;
      integer k;
      begin
         crf_lowest = {IW{1'b0}};
         for (k = NBUF - 1; k >= 0; k = k - 1)
         begin
            if (v[k])
            begin
               crf_lowest = k[IW-1:0];
            end
         end
      end
   endfunction

   // unmasked first, then lowest number within a type
   assign plain_hit = hit & ~masked;
   assign mask_hit = hit & masked;
   assign plain_idx = crf_lowest(plain_hit); // see (R7)
   assign mask_idx = crf_lowest(mask_hit); // see (R7)
   assign found = |hit;
   assign via_mask = ~(|plain_hit); // see (R6)
   assign idx = via_mask ? mask_idx : plain_idx; // see (R6)
endmodule // crf_pick

//--- core/crf_skid.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module crf_skid #(
   parameter W = 35
) (
   clk,
   sys_rst,
   in_valid,
   in_ready,
   in_data,
   out_valid,
   out_ready,
   out_data
);
   input wire clk;
   input wire sys_rst;
   input wire in_valid;
   output reg in_ready;
   input wire [W-1:0] in_data;
   output reg out_valid;
   input wire out_ready;
   output reg [W-1:0] out_data;

   reg spare_v_ff;
   reg [W-1:0] spare_ff;
   reg nxt_spare_v;
   reg nxt_out_v;
   reg [W-1:0] nxt_spare;
   reg [W-1:0] nxt_out;
   wire push;

   assign push = in_valid & in_ready;

   // head is the output register, spare catches a word during a stall
   always @*
   begin
      nxt_spare_v = spare_v_ff;
      nxt_spare = spare_ff;
      nxt_out_v = out_valid;
      nxt_out = out_data;
      if (out_ready | ~out_valid)
      begin
         if (spare_v_ff)
         begin
            nxt_out_v = 1'b1;
            nxt_out = spare_ff;
            nxt_spare_v = 1'b0;
         end
         else
         begin
            nxt_out_v = push;
            nxt_out = in_data;
         end
      end
      else if (push)
      begin
         nxt_spare_v = 1'b1;
         nxt_spare = in_data;
      end
   end

   // state update
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         spare_v_ff <= 1'b0;
         spare_ff <= {W{1'b0}};
         out_valid <= 1'b0;
         out_data <= {W{1'b0}};
         in_ready <= 1'b1;
      end
      else
      begin
         spare_v_ff <= nxt_spare_v;
         spare_ff <= nxt_spare;
         out_valid <= nxt_out_v;
         out_data <= nxt_out;
         in_ready <= ~nxt_spare_v;
      end
   end
endmodule // crf_skid

//--- core/crf_top.v
// receive acceptance filter, buffer rewrite control and interrupt sources
`timescale 1ns/100ps
`include "crf_map.vh"
module crf_top #(
   parameter NBUF = 16,
   parameter IW = 4
) (
   clk,
   sys_rst,
   cpu_addr,
   cpu_wr,
   cpu_rd,
   cpu_wdata,
   cpu_rdata_ff,
   ctl_init,
   quantum_range_enable,
   tq_range_sel_ff,
   tq_max_clocks_ff,
   buf_id_flat,
   buf_ide,
   buf_eni,
   dn_clr,
   fresh_message_flag_ff,
   rx_valid,
   rx_frame_ok,
   rx_id,
   rx_ide,
   rx_ready,
   store_valid,
   store_ready,
   store_idx,
   store_id,
   store_id_wr,
   tx_set,
   tx_cancel_set,
   tx_done,
   transmit_request_ff,
   transmit_cancel_request_ff,
   bus_off_state,
   transmit_error_level,
   receive_error_level,
   overrun_evt,
   wake_evt,
   wake_clr,
   wake_flag_ff,
   fault_interrupt_flag_ff,
   rx_interrupt_flag_ff,
   tx0_interrupt_flag_ff,
   tx1_interrupt_flag_ff
);
   input wire clk;
   input wire sys_rst;
   input wire [15:0] cpu_addr;
   input wire cpu_wr;
   input wire cpu_rd;
   input wire [7:0] cpu_wdata;
   output reg [7:0] cpu_rdata_ff;
   input wire ctl_init;
   input wire quantum_range_enable;
   output reg [1:0] tq_range_sel_ff;
   output reg [8:0] tq_max_clocks_ff;
   input wire [NBUF*`CRF_ID_W-1:0] buf_id_flat;
   input wire [NBUF-1:0] buf_ide;
   input wire [NBUF-1:0] buf_eni;
   input wire [NBUF-1:0] dn_clr;
   output reg [NBUF-1:0] fresh_message_flag_ff;
   input wire rx_valid;
   input wire rx_frame_ok;
   input wire [`CRF_ID_W-1:0] rx_id;
   input wire rx_ide;
   output wire rx_ready;
   output wire store_valid;
   input wire store_ready;
   output wire [IW-1:0] store_idx;
   output wire [`CRF_ID_W-1:0] store_id;
   output wire store_id_wr;
   input wire [1:0] tx_set;
   input wire [1:0] tx_cancel_set;
   input wire [1:0] tx_done;
   output reg [1:0] transmit_request_ff;
   output reg [1:0] transmit_cancel_request_ff;
   input wire bus_off_state;
   input wire transmit_error_level;
   input wire receive_error_level;
   input wire overrun_evt;
   input wire wake_evt;
   input wire wake_clr;
   output reg wake_flag_ff;
   output reg fault_interrupt_flag_ff;
   output reg rx_interrupt_flag_ff;
   output reg tx0_interrupt_flag_ff;
   output reg tx1_interrupt_flag_ff;

   localparam PW = `CRF_ID_W + IW + 2;

   reg [7:0] filter_mask_config_ff;
   reg rewrite_permit_ff;
   reg [3:0] buffer_pick_code_ff;
   reg [2:0] err_prev_ff;
   wire first_mask_enable;
   wire second_mask_enable;
   wire global_mask;
   wire [`CRF_ID_W-1:0] mask0_bits;
   wire [`CRF_ID_W-1:0] mask1_bits;
   wire [NBUF-1:0] hit;
   wire [NBUF-1:0] masked;
   wire found;
   wire via_mask;
   wire [IW-1:0] win_idx;
   wire push_valid;
   wire [PW-1:0] push_data;
   wire [PW-1:0] pop_data;
   wire pop;
   wire pop_eni;
   wire wr_rewrite;
   wire wr_maskcfg;
   wire err_change;
   reg [7:0] nxt_rdata;
   wire [7:0] rw_rst = `CRF_REWRITE_RST;

   // which mask, if any, a buffer compares through
   function [1:0] crf_mask_src;
      input integer n;
      input m0;
      input m1;
      input g;
      begin
         crf_mask_src = `CRF_SRC_NONE;
         if ((n == 0 && m0) || (n == 2 && m1))
         begin
            crf_mask_src = `CRF_SRC_ISMASK;
         end
         else if (n == 1 && m0)
         begin
            crf_mask_src = `CRF_SRC_MASK0;
         end
         else if (n == 2 && g && m0)
         begin
            crf_mask_src = `CRF_SRC_MASK0;
         end
         else if (n == 3 && m1 && ~g)
         begin
            crf_mask_src = `CRF_SRC_MASK1;
         end
         else if (n >= 4 && g && m1)
         begin
            crf_mask_src = `CRF_SRC_MASK1;
         end
         else if (n >= 4 && g && m0)
         begin
            crf_mask_src = `CRF_SRC_MASK0;
         end
      end
   endfunction

   assign first_mask_enable = filter_mask_config_ff[`CRF_MC_MASK1];
   assign second_mask_enable = filter_mask_config_ff[`CRF_MC_MASK2];
   assign global_mask = filter_mask_config_ff[`CRF_MC_GLOBAL];
   assign mask0_bits = buf_id_flat[0*`CRF_ID_W +: `CRF_ID_W]; // see (R23)
   assign mask1_bits = buf_id_flat[2*`CRF_ID_W +: `CRF_ID_W]; // see (R23)

   // per-buffer comparison of the incoming identifier
   genvar gi;
   generate
      for (gi = 0; gi < NBUF; gi = gi + 1)
      begin : g_cmp
         wire [1:0] src;
         wire [`CRF_ID_W-1:0] fmt_bits;
         wire [`CRF_ID_W-1:0] use_bits;
         wire excluded;
         assign src = crf_mask_src(gi, first_mask_enable, second_mask_enable,
                                   global_mask); // see (R2) (R4) (R24)
         assign fmt_bits = buf_ide[gi] ? `CRF_EXT_BITS : `CRF_STD_BITS;
         assign use_bits = (src == `CRF_SRC_MASK0) ? mask0_bits :
                           (src == `CRF_SRC_MASK1) ? mask1_bits :
                           `CRF_EXT_BITS; // see (R4)
         assign excluded = rewrite_permit_ff &&
                           (buffer_pick_code_ff == gi); // see (R8) (R9)
         assign masked[gi] = (src == `CRF_SRC_MASK0) || (src == `CRF_SRC_MASK1);
         assign hit[gi] = (src != `CRF_SRC_ISMASK) && ~excluded && // see (R3)
                          (buf_ide[gi] == rx_ide) && // see (R5)
                          (((rx_id ^ buf_id_flat[gi*`CRF_ID_W +: `CRF_ID_W]) &
                            fmt_bits & use_bits) == {`CRF_ID_W{1'b0}}); // see (R2)
      end
   endgenerate

   // one winner per message
   crf_pick #(
      .NBUF(NBUF),
      .IW(IW)
   ) u_pick (
      .hit(hit),
      .masked(masked),
      .found(found),
      .idx(win_idx),
      .via_mask(via_mask)
   );

   // queued stores finish even if the permit rises later
   assign push_valid = rx_valid & rx_frame_ok & found; // see (R19) (R10)
   assign push_data = {buf_eni[win_idx], via_mask, win_idx, rx_id};

   crf_skid #(
      .W(PW)
   ) u_skid (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(push_valid),
      .in_ready(rx_ready),
      .in_data(push_data),
      .out_valid(store_valid),
      .out_ready(store_ready),
      .out_data(pop_data)
   );

   assign store_id = pop_data[`CRF_ID_W-1:0];
   assign store_idx = pop_data[`CRF_ID_W +: IW];
   assign store_id_wr = pop_data[`CRF_ID_W+IW]; // see (R15)
   assign pop_eni = pop_data[`CRF_ID_W+IW+1];
   assign pop = store_valid & store_ready;

   // register decode
   assign wr_rewrite = cpu_wr && (cpu_addr == `CRF_ADDR_REWRITE);
   assign wr_maskcfg = cpu_wr && (cpu_addr == `CRF_ADDR_MASKCFG) && ctl_init;

   // read data mux, unmapped addresses read zero
   always @*
   begin
      nxt_rdata = 8'h00;
      case (cpu_addr)
         `CRF_ADDR_FRESH:
         begin
            nxt_rdata = fresh_message_flag_ff[7:0];
         end
         `CRF_ADDR_REWRITE:
         begin
            nxt_rdata = {rewrite_permit_ff, 3'h0, buffer_pick_code_ff}; // see (R12)
         end
         `CRF_ADDR_MASKCFG:
         begin
            nxt_rdata = filter_mask_config_ff;
         end
         default:
         begin
            nxt_rdata = 8'h00;
         end
      endcase
   end

   // configuration registers and prescaler range
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         cpu_rdata_ff <= 8'h00;
         filter_mask_config_ff <= `CRF_MASKCFG_RST;
         rewrite_permit_ff <= rw_rst[`CRF_RW_PERMIT]; // see (R12)
         buffer_pick_code_ff <= rw_rst[`CRF_RW_PICK_HI:`CRF_RW_PICK_LO];
         tq_range_sel_ff <= 2'h0;
         tq_max_clocks_ff <= `CRF_TQ_STEP;
      end
      else
      begin
         if (cpu_rd)
         begin
            cpu_rdata_ff <= nxt_rdata;
         end
         if (wr_maskcfg)
         begin
            filter_mask_config_ff <= cpu_wdata & `CRF_MASKCFG_RW;
         end
         if (wr_rewrite)
         begin
            buffer_pick_code_ff <= cpu_wdata[`CRF_RW_PICK_HI:`CRF_RW_PICK_LO]; // see (R8)
         end
         if (ctl_init)
         begin
            rewrite_permit_ff <= 1'b0; // see (R11)
         end
         else if (wr_rewrite)
         begin
            rewrite_permit_ff <= cpu_wdata[`CRF_RW_PERMIT]; // see (R8)
         end
         if (quantum_range_enable)
         begin
            tq_range_sel_ff <= filter_mask_config_ff[`CRF_MC_RANGE_HI:`CRF_MC_RANGE_LO]; // see (R25)
            tq_max_clocks_ff <= {filter_mask_config_ff[`CRF_MC_RANGE_HI:`CRF_MC_RANGE_LO],
                                 6'h00} + `CRF_TQ_STEP; // see (R1)
         end
         else
         begin
            tq_range_sel_ff <= 2'h0;
            tq_max_clocks_ff <= `CRF_TQ_STEP;
         end
      end
   end

   // fresh flags and receive interrupt at completed store
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         fresh_message_flag_ff <= {NBUF{1'b0}};
         rx_interrupt_flag_ff <= 1'b0;
      end
      else
      begin
         if (ctl_init)
         begin
            fresh_message_flag_ff <= {NBUF{1'b0}};
         end
         else
         begin
            fresh_message_flag_ff <= (fresh_message_flag_ff & ~dn_clr) |
                                     ({{(NBUF-1){1'b0}}, pop} << store_idx); // see (R26)
         end
         rx_interrupt_flag_ff <= pop & pop_eni; // see (R19) (R20)
      end
   end

   // transmit requests: software sets, the controller or an initialization request clears
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         transmit_request_ff <= 2'h0;
         transmit_cancel_request_ff <= 2'h0;
         tx0_interrupt_flag_ff <= 1'b0;
         tx1_interrupt_flag_ff <= 1'b0;
      end
      else
      begin
         if (ctl_init)
         begin
            transmit_request_ff <= 2'h0;
            transmit_cancel_request_ff <= 2'h0;
         end
         else
         begin
            transmit_request_ff <= (transmit_request_ff | tx_set) & ~tx_done; // see (R18)
            transmit_cancel_request_ff <= (transmit_cancel_request_ff |
                                           (tx_cancel_set & transmit_request_ff)) &
                                          ~tx_done; // see (R18)
         end
         tx0_interrupt_flag_ff <= tx_done[0] & transmit_request_ff[0]; // see (R17) (R16)
         tx1_interrupt_flag_ff <= tx_done[1] & transmit_request_ff[1]; // see (R17) (R16)
      end
   end

   assign err_change = (err_prev_ff != {bus_off_state, transmit_error_level,
                                        receive_error_level});

   // fault source, held off while the wake flag stands
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         err_prev_ff <= 3'h0;
         wake_flag_ff <= 1'b0;
         fault_interrupt_flag_ff <= 1'b0;
      end
      else
      begin
         err_prev_ff <= {bus_off_state, transmit_error_level, receive_error_level};
         wake_flag_ff <= wake_evt | (wake_flag_ff & ~wake_clr); // see (R22)
         fault_interrupt_flag_ff <= ~wake_flag_ff &
                                    (err_change | overrun_evt | wake_evt); // see (R21) (R22)
      end
   end
endmodule // crf_top

//--- testbench/crf_ram_model.sv
// buffer ram stand-in: fast, slow or stalled
`timescale 1ns/100ps
module crf_ram_model (
   input wire clk,
   input wire sys_rst,
   input wire stall,
   input wire slow,
   output reg store_ready
);
   reg [1:0] phase_ff;
   // free running phase paces the slow answer
   always @(posedge clk)
   begin
      phase_ff <= sys_rst ? 2'b00 : phase_ff + 2'b01;
   end
   // ready never while stalled, one cycle in four when slow
   always @*
   begin
      store_ready = !stall && (!slow || phase_ff == 2'b00);
   end
endmodule // crf_ram_model

//--- testbench/crf_top_properties.sv
// concurrent checks on the ports of the receive filter block
`timescale 1ns/100ps
module crf_props #(
   parameter NBUF = 16,
   parameter IW = 4
) (
   input clk,
   input sys_rst,
   input [15:0] cpu_addr,
   input cpu_rd,
   input [7:0] cpu_rdata_ff,
   input ctl_init,
   input quantum_range_enable,
   input [1:0] tq_range_sel_ff,
   input [8:0] tq_max_clocks_ff,
   input [NBUF-1:0] fresh_message_flag_ff,
   input store_valid,
   input store_ready,
   input [IW-1:0] store_idx,
   input [1:0] tx_done,
   input [1:0] transmit_request_ff,
   input bus_off_state,
   input transmit_error_level,
   input receive_error_level,
   input overrun_evt,
   input wake_evt,
   input wake_flag_ff,
   input fault_interrupt_flag_ff,
   input rx_interrupt_flag_ff,
   input tx0_interrupt_flag_ff,
   input tx1_interrupt_flag_ff
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // transmit completion and its interrupt
   tx0_irq_due_a: assert property (tx_done[0] && transmit_request_ff[0] |=>
      tx0_interrupt_flag_ff && !transmit_request_ff[0]) else $error("tx0 irq missing");
   tx1_irq_due_a: assert property (tx_done[1] && transmit_request_ff[1] |=>
      tx1_interrupt_flag_ff && !transmit_request_ff[1]) else $error("tx1 irq missing");
   tx0_irq_cause_a: assert property (tx0_interrupt_flag_ff |->
      $past(tx_done[0] && transmit_request_ff[0])) else $error("tx0 irq without cause");
   tx_clear_cause_a: assert property ($fell(transmit_request_ff[1]) |->
      $past(tx_done[1] || ctl_init)) else $error("tx request cleared by nobody");
   // fault interrupt sources and muting by the wake flag
   fault_cause_a: assert property (($changed(bus_off_state) ||
      $changed(transmit_error_level) || $changed(receive_error_level) || overrun_evt ||
      wake_evt) && !wake_flag_ff |=> fault_interrupt_flag_ff) else $error("fault irq missing");
   wake_mute_a: assert property (fault_interrupt_flag_ff |-> !$past(wake_flag_ff))
      else $error("fault irq while wake flag set");
   // receive store, its interrupt and fresh flag
   rx_irq_cause_a: assert property (rx_interrupt_flag_ff |->
      $past(store_valid && store_ready)) else $error("rx irq without store");
   store_hold_a: assert property (store_valid && !store_ready |=>
      store_valid && $stable(store_idx)) else $error("store request dropped");
   fresh_set_a: assert property (store_valid && store_ready && !ctl_init |=>
      fresh_message_flag_ff[$past(store_idx)]) else $error("fresh flag not set");
   // rewrite control readback
   rw_zero_bits_a: assert property (cpu_rd && cpu_addr == 16'hffb3 |=>
      cpu_rdata_ff[6:4] == 3'b000) else $error("rewrite bits 6 to 4 not zero");
   init_permit_a: assert property (ctl_init ##1 (cpu_rd && cpu_addr == 16'hffb3) |=>
      !cpu_rdata_ff[7]) else $error("permit survives init");
   // quantum range
   tq_top_a: assert property (tq_max_clocks_ff == {1'b0, tq_range_sel_ff, 6'b0} + 9'h040)
      else $error("quantum range top wrong");
   tq_off_a: assert property (!quantum_range_enable |=>
      tq_range_sel_ff == 2'b00) else $error("range bits act while disabled");
endmodule // crf_props
bind crf_top crf_props #(.NBUF(NBUF), .IW(IW)) crf_props_i (.*);

//--- testbench/testbench.sv
// self-checking bench of the receive filter block
`timescale 1ns/100ps
module testbench;
   localparam [28:0] ID_A = 29'h1554_0000;
   localparam [28:0] ID_M = 29'h1ff8_0000;
   reg clk = 1'b0;
   reg sys_rst, cpu_wr, cpu_rd, ctl_init, quantum_range_enable, rx_valid, rx_frame_ok, rx_ide;
   reg bus_off_state, transmit_error_level, receive_error_level, overrun_evt, wake_evt, wake_clr;
   reg stall, slow, rd_due, irq_due, irq_eni, saw_full;
   reg [15:0] cpu_addr, buf_ide, buf_eni, dn_clr, seed;
   reg [7:0] cpu_wdata;
   reg [28:0] rx_id;
   reg [1:0] tx_set, tx_cancel_set, tx_done;
   reg [3:0] irq_idx;
   reg [2:0] cfg;
   reg [16*29-1:0] buf_id_flat;
   wire [7:0] cpu_rdata_ff;
   wire [1:0] tq_range_sel_ff, transmit_request_ff, transmit_cancel_request_ff;
   wire [8:0] tq_max_clocks_ff;
   wire [15:0] fresh_message_flag_ff;
   wire [3:0] store_idx;
   wire [28:0] store_id;
   wire rx_ready, store_valid, store_ready, store_id_wr, wake_flag_ff;
   wire fault_interrupt_flag_ff, rx_interrupt_flag_ff, tx0_interrupt_flag_ff, tx1_interrupt_flag_ff;
   int n_errors = 0;
   int n_checks = 0;
   int n_fault = 0;
   int ex, key, m, f, n;
   logic [31:0] rdq[$];
   int stq[$];
   logic [28:0] idq[$];
   crf_top crf_top_i (.*);
   crf_ram_model crf_ram_model_i (.*);
   always #4 clk = ~clk;
   task cyc;
      @(posedge clk);
   endtask
   task check(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task close_out;
      if (n_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task wr(input [15:0] a, input [7:0] d);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_wr <= 1'b1;
      cyc;
      cpu_wr <= 1'b0;
      cyc;
   endtask
   task rd(input [15:0] a, input [7:0] e);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      rdq.push_back(e);
      cyc;
      cpu_rd <= 1'b0;
      cyc;
   endtask
   task cfg_wr(input [7:0] d);
      ctl_init <= 1'b1;
      wr(16'hffbb, d);
      ctl_init <= 1'b0;
      cfg = d[2:0];
   endtask
   // expected target: index, plus 16 if masked
   function automatic int exp_pick(input [28:0] fid, input fide);
      int best;
      int r;
      logic [28:0] fm;
      best = -1;
      for (int i = 0; i < 16; i++)
      begin
         r = 0;
         if ((i == 0 && cfg[0]) || (i == 2 && cfg[1]))
            r = 3;
         else if ((i == 1 && cfg[0]) || (i == 2 && cfg == 3'b101))
            r = 1;
         else if (i == 3 && cfg[1] && !cfg[2])
            r = 2;
         else if (i > 3 && cfg[2])
            r = cfg[1] ? 2 : (cfg[0] ? 1 : 0);
         fm = buf_ide[i] ? 29'h1fff_ffff : 29'h1ffc_0000;
         fm = fm & (r == 1 || r == 2 ? ID_M : 29'h1fff_ffff);
         if (r != 3 && buf_ide[i] == fide && i != ex && ((fid ^ buf_id_flat[i*29 +: 29]) & fm) == 0)
            if (best < 0 || (r != 0 ? 16 : 0) + i < best)
               best = (r != 0 ? 16 : 0) + i;
      end
      return best;
   endfunction
   task send(input [28:0] id, input ide, input ok);
      key = exp_pick(id, ide);
      if (ok && key >= 0)
      begin
         stq.push_back(key);
         idq.push_back(id);
      end
      rx_id <= id;
      rx_ide <= ide;
      rx_frame_ok <= ok;
      rx_valid <= 1'b1;
      cyc;
      while (!rx_ready)
         cyc;
      rx_valid <= 1'b0;
      cyc;
   endtask
   task txo(input [1:0] s, input [1:0] c, input [1:0] d);
      tx_set <= s;
      tx_cancel_set <= c;
      tx_done <= d;
      cyc;
      {tx_set, tx_cancel_set, tx_done} <= 6'h00;
      cyc;
   endtask
   task evp(input [2:0] v);
      {wake_clr, wake_evt, overrun_evt} <= v;
      cyc;
      {wake_clr, wake_evt, overrun_evt} <= 3'h0;
      repeat (3) cyc;
   endtask
   // scoreboard: oldest note per result
   always @(posedge clk)
   begin
      rd_due <= cpu_rd;
      if (rd_due)
         check("read data", cpu_rdata_ff, rdq.pop_front());
      saw_full <= saw_full | (rx_valid & !rx_ready);
      n_fault <= n_fault + (sys_rst ? 0 : fault_interrupt_flag_ff);
      if (!sys_rst)
         check("rx irq", rx_interrupt_flag_ff, irq_due && irq_eni);
      if (irq_due)
         check("fresh flag", fresh_message_flag_ff[irq_idx], 1'b1);
      irq_due <= store_valid && store_ready;
      irq_eni <= buf_eni[store_idx];
      irq_idx <= store_idx;
      if (store_valid && store_ready && stq.size() == 0)
         check("stray store", 1'b1, 1'b0);
      else if (store_valid && store_ready)
      begin
         key = stq.pop_front();
         check("store idx", store_idx, key % 16);
         check("store id wr", store_id_wr, key / 16);
         check("store id", store_id, idq.pop_front());
      end
   end
   // watchdog cuts a hang short
   initial
   begin
      #60000;
      n_errors++;
      close_out;
   end
   // main sequence
   initial
   begin
      {sys_rst, cpu_wr, cpu_rd, ctl_init, quantum_range_enable, rx_valid, rx_frame_ok} = 7'h01 << 6;
      {rx_ide, bus_off_state, transmit_error_level, receive_error_level} = 4'h0;
      {overrun_evt, wake_evt, wake_clr, stall, slow, rd_due, irq_due, irq_eni, saw_full} = 9'h000;
      {cpu_addr, buf_ide, buf_eni, dn_clr, cpu_wdata, rx_id} = 0;
      {tx_set, tx_cancel_set, tx_done, irq_idx} = 0;
      seed = 16'h2634;
      cfg = 3'h0;
      ex = -1;
      for (int i = 0; i < 16; i++)
         buf_id_flat[i*29 +: 29] = (i == 0 || i == 2) ? ID_M : ID_A;
      repeat (10) cyc;
      sys_rst <= 1'b0;
      rd(16'hffb3, 8'h00);
      rd(16'hffbb, 8'h00);
      rd(16'hffb0, 8'h00);
      wr(16'hffb3, 8'h7f);
      rd(16'hffb3, 8'h0f);
      wr(16'hffb3, 8'h8f);
      rd(16'hffb3, 8'h8f);
      ctl_init <= 1'b1;
      cyc;
      ctl_init <= 1'b0;
      rd(16'hffb3, 8'h0f);
      wr(16'hffbb, 8'h03);
      rd(16'hffbb, 8'h00);
      for (m = 0; m < 8; m++)
      begin
         cfg_wr(m[7:0]);
         rd(16'hffbb, m[7:0]);
         for (f = 0; f < 4; f++)
         begin
            seed = lfsr(seed);
            buf_eni <= seed;
            buf_ide <= f[1] ? {seed[7:0], seed[15:8]} : 16'h0000;
            slow <= seed[5];
            cyc;
            send(f[0] ? ID_A ^ 29'h0004_0000 : ID_A, f[1] & seed[0], 1'b1);
            repeat (6) cyc;
         end
      end
      send(ID_A, 1'b0, 1'b0);
      wr(16'hffb3, 8'h01);
      wr(16'hffb3, 8'h81);
      ex = 1;
      send(ID_A, 1'b0, 1'b1);
      wr(16'hffb3, 8'h01);
      ex = -1;
      repeat (6) cyc;
      // stalled ram fills the buffer
      stall <= 1'b1;
      send(ID_A, 1'b0, 1'b1);
      wr(16'hffb3, 8'h81);
      ex = 1;
      fork
         begin
            repeat (30) cyc;
            stall <= 1'b0;
         end
         for (n = 0; n < 4; n++)
            send(ID_A, 1'b0, 1'b1);
      join
      repeat (20) cyc;
      check("buffer full", saw_full, 1'b1);
      for (n = 0; n < 4; n++)
      begin
         cfg_wr({n[1:0], 6'h00});
         quantum_range_enable <= 1'b1;
         repeat (3) cyc;
         check("tq sel", tq_range_sel_ff, n);
         check("tq top", tq_max_clocks_ff, 64 * n + 64);
         quantum_range_enable <= 1'b0;
         repeat (3) cyc;
         check("tq off", tq_range_sel_ff, 0);
      end
      for (n = 0; n < 2; n++)
      begin
         txo(2'b01 << n, 2'b00, 2'b00);
         check("tx req", transmit_request_ff[n], 1'b1);
         txo(2'b00, 2'b01 << n, 2'b00);
         check("tx cancel", transmit_cancel_request_ff[n], 1'b1);
         check("tx kept", transmit_request_ff[n], 1'b1);
         txo(2'b00, 2'b00, 2'b01 << n);
         check("tx cleared", transmit_request_ff[n], 1'b0);
         txo(2'b00, 2'b00, 2'b01 << n);
      end
      bus_off_state <= 1'b1;
      repeat (3) cyc;
      transmit_error_level <= 1'b1;
      repeat (3) cyc;
      receive_error_level <= 1'b1;
      repeat (3) cyc;
      evp(3'b001);
      evp(3'b010);
      evp(3'b001);
      check("wake flag", wake_flag_ff, 1'b1);
      check("fault count", n_fault, 5);
      evp(3'b100);
      evp(3'b001);
      check("fault after clear", n_fault, 6);
      dn_clr <= 16'hffff;
      cyc;
      dn_clr <= 16'h0000;
      rd(16'hffb2, 8'h00);
      check("notes left", stq.size(), 0);
      close_out;
   end
endmodule // testbench
